// file: compare_pin.sv
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"

// one compare output pin; matches arrive as one-cycle pulses
module compare_pin
	import pwm_timer_pkg::*;
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// configuration
	input  wire logic       pwm_mode_in,
	input  wire logic [3:0] io_a_in,
	input  wire logic [3:0] io_b_in,
	input  wire logic       use_a_field_in,
	input  wire logic       cfg_write_in,
	// match events
	input  wire logic       match_a_in,
	input  wire logic       match_b_in,
	// pin
	output logic            pin_out
);
	pin_state_t state_q;

	// level driven on match: codes 1/2/3 = low/high/toggle, 0 = pin keeps its level
	function automatic logic next_level(input logic [3:0] io, input logic cur);
		case (io[1:0])
			2'h1:    next_level = 1'b0;
			2'h2:    next_level = 1'b1;
			2'h3:    next_level = ~cur;
			default: next_level = cur;
		endcase
	endfunction

	// initial level lives in bit 2 of the field: clear gives 0, set gives 1
	function automatic logic init_level(input logic [3:0] io);
		init_level = io[2] | (io[1:0] == 2'h2 ? 1'b0 : 1'b0);
	endfunction

	// a config write reloads the initial level, then the pin follows matches
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_q <= PIN_IDLE;
			pin_out <= 1'b0;
		end else begin
			case (state_q)
				PIN_IDLE, PIN_RUN: begin
					if (cfg_write_in) begin
						state_q <= PIN_INIT;
					end else if (pwm_mode_in) begin
						state_q <= PIN_RUN;
						if (match_b_in)
							pin_out <= next_level(io_b_in, pin_out);
						else if (match_a_in)
							pin_out <= next_level(io_a_in, pin_out);
					end else if (match_a_in && use_a_field_in) begin
						state_q <= PIN_RUN;
						pin_out <= next_level(io_a_in, pin_out);
					end else if (match_b_in && !use_a_field_in) begin
						state_q <= PIN_RUN;
						pin_out <= next_level(io_b_in, pin_out);
					end
				end
				PIN_INIT: begin
					state_q <= PIN_RUN;
					pin_out <= use_a_field_in ? init_level(io_a_in) : init_level(io_b_in);
				end
				default: state_q <= PIN_IDLE;
			endcase
		end
	end
endmodule

// file: prescale_divider.sv
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"

// free-running divider giving one-cycle tick pulses at /1, /4, /16, /64
module prescale_divider
	import pwm_timer_pkg::*;
#(
	parameter int DIV_WIDTH = 6
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// tick outputs
	output logic      tick_div1_out,
	output logic      tick_div4_out,
	output logic      tick_div16_out,
	output logic      tick_div64_out
);
	logic [DIV_WIDTH-1:0] div_q;

	initial begin
		if (DIV_WIDTH < 6)
			$error("divider too narrow for the /64 tap");
	end

	// one shared counter keeps all taps phase aligned between channels
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end

	// taps pulse when the low bits wrap
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tick_div1_out  <= 1'b0;
			tick_div4_out  <= 1'b0;
			tick_div16_out <= 1'b0;
			tick_div64_out <= 1'b0;
		end else begin
			tick_div1_out  <= 1'b1;
			tick_div4_out  <= (div_q[1:0] == 2'h3);
			tick_div16_out <= (div_q[3:0] == 4'hf);
			tick_div64_out <= (div_q[5:0] == 6'h3f);
		end
	end
endmodule

// file: pwm_timer_consts.svh
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH

// register byte addresses
`define ADDR_START_CTRL   16'hf030
`define ADDR_SYNC_SEL     16'hf031
`define ADDR_CH1_CTRL     16'hf040
`define ADDR_CH1_MODE     16'hf041
`define ADDR_CH1_IO       16'hf042
`define ADDR_CH1_COUNT    16'hf046
`define ADDR_CH1_DUTY     16'hf048
`define ADDR_CH1_PERIOD   16'hf04a
`define ADDR_CH2_CTRL     16'hf050
`define ADDR_CH2_IO       16'hf052
`define ADDR_CH2_COUNT    16'hf056
`define ADDR_CH2_DUTY     16'hf058
`define ADDR_CH2_PERIOD   16'hf05a

// field positions
`define BIT_RUN_CH1       1
`define BIT_RUN_CH2       2
`define BIT_LOCK_CH1      1
`define BIT_LOCK_CH2      2
`define CLR_SRC_HI        6
`define CLR_SRC_LO        5
`define EDGE_HI           4
`define EDGE_LO           3
`define PSC_HI            2
`define PSC_LO            0
`define MODE_HI           1
`define MODE_LO           0
`define IOB_HI            7
`define IOB_LO            4
`define IOA_HI            3
`define IOA_LO            0

// field codes
`define CLR_NONE          2'h0
`define CLR_ON_A          2'h1
`define CLR_ON_B          2'h2
`define CLR_ON_SYNC       2'h3
`define EDGE_RISING       2'h0
`define PSC_DIV1          3'h0
`define PSC_DIV4          3'h1
`define PSC_DIV16         3'h2
`define PSC_DIV64         3'h3
`define MODE_NORMAL       2'h0
`define MODE_PWM1         2'h2

// reset values
`define RST_CTRL8         8'h00
`define RST_COUNT         16'h0000
`define RST_COMPARE       16'hffff

// prescaler ratios
`define DIV4_COUNT        4
`define DIV16_COUNT       16
`define DIV64_COUNT       64

`endif

// file: pwm_timer_pkg.sv
package pwm_timer_pkg;
	typedef logic [15:0] count_t;
	typedef logic [7:0]  reg8_t;
	typedef enum logic [2:0] {
		PIN_INIT  = 3'h1,
		PIN_RUN   = 3'h2,
		PIN_IDLE  = 3'h4
	} pin_state_t;
endpackage

// file: synced_two_channel_pwm_timer.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "pwm_timer_consts.svh"

module synced_two_channel_pwm_timer
	import pwm_timer_pkg::*;
#(
	parameter int ADDR_WIDTH = 16,
	parameter int DATA_WIDTH = 16
) (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  reset_in,
	// register port
	input  wire logic [ADDR_WIDTH-1:0] addr_in,
	input  wire logic [DATA_WIDTH-1:0] wdata_in,
	input  wire logic                  write_in,
	input  wire logic                  read_in,
	output logic      [DATA_WIDTH-1:0] rdata_out,
	// compare pins
	output logic                       ch1_pwm_pin_out,
	output logic                       ch1_aux_compare_pin_out,
	output logic                       ch2_pwm_pin_out
);
	initial begin
		if (ADDR_WIDTH != 16 || DATA_WIDTH != 16)
			$error("register port must be 16-bit address and 16-bit data");
	end

	// control registers
	// channel 2 mode and io stay byte wide like their channel 1 twins
	reg8_t  start_q;
	reg8_t  sync_q;
	reg8_t  ch1_ctrl_q;
	reg8_t  ch1_mode_q;
	reg8_t  ch1_io_q;
	reg8_t  ch2_ctrl_q;
	reg8_t  ch2_mode_q;
	reg8_t  ch2_io_q;
	// counters and compares
	count_t ch1_count_q;
	count_t ch2_count_q;
	count_t ch1_duty_q;
	count_t ch1_period_q;
	count_t ch2_duty_q;
	count_t ch2_period_q;

	// prescaler ticks
	// ticks are registered one-cycle pulses from the shared divider
	logic tick1;
	logic tick4;
	logic tick16;
	logic tick64;

	// one divider serves both channels so their ticks never drift apart
	prescale_divider #(
		.DIV_WIDTH (6)
	) u_div (
		.clk_in         (clk_in),
		.reset_in       (reset_in),
		.tick_div1_out  (tick1),
		.tick_div4_out  (tick4),
		.tick_div16_out (tick16),
		.tick_div64_out (tick64)
	);

	// tick selection from a control register's prescaler field
	// codes above /64 select no tick and leave the counter still
	function automatic logic pick_tick(input reg8_t ctrl, input logic t1, input logic t4,
		input logic t16, input logic t64);
		case (ctrl[`PSC_HI:`PSC_LO])
			`PSC_DIV1:  pick_tick = t1;
			`PSC_DIV4:  pick_tick = t4;
			`PSC_DIV16: pick_tick = t16;
			`PSC_DIV64: pick_tick = t64;
			default:    pick_tick = 1'b0;
		endcase
	endfunction

	// address decode compares the whole byte address, so an odd address
	// aimed at the low byte of a 16-bit register is simply ignored: software
	// must move counters and compares as whole words
	// write decode
	function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
		hit = (a == target);
	endfunction

	logic wr_start, wr_sync, wr_c1ctrl, wr_c1mode, wr_c1io, wr_c1cnt;
	logic wr_c1duty, wr_c1per, wr_c2ctrl, wr_c2io, wr_c2cnt, wr_c2duty, wr_c2per;
	assign wr_start  = write_in && hit(addr_in, `ADDR_START_CTRL);
	assign wr_sync   = write_in && hit(addr_in, `ADDR_SYNC_SEL);
	assign wr_c1ctrl = write_in && hit(addr_in, `ADDR_CH1_CTRL);
	assign wr_c1mode = write_in && hit(addr_in, `ADDR_CH1_MODE);
	assign wr_c1io   = write_in && hit(addr_in, `ADDR_CH1_IO);
	assign wr_c1cnt  = write_in && hit(addr_in, `ADDR_CH1_COUNT);
	assign wr_c1duty = write_in && hit(addr_in, `ADDR_CH1_DUTY);
	assign wr_c1per  = write_in && hit(addr_in, `ADDR_CH1_PERIOD);
	assign wr_c2ctrl = write_in && hit(addr_in, `ADDR_CH2_CTRL);
	assign wr_c2io   = write_in && hit(addr_in, `ADDR_CH2_IO);
	assign wr_c2cnt  = write_in && hit(addr_in, `ADDR_CH2_COUNT);
	assign wr_c2duty = write_in && hit(addr_in, `ADDR_CH2_DUTY);
	assign wr_c2per  = write_in && hit(addr_in, `ADDR_CH2_PERIOD);

	// status of each channel
	// run, lock and mode bits are read straight from their registers
	logic run1, run2, lock1, lock2, pwm1, pwm2;
	assign run1  = start_q[`BIT_RUN_CH1];
	assign run2  = start_q[`BIT_RUN_CH2];
	assign lock1 = sync_q[`BIT_LOCK_CH1];
	assign lock2 = sync_q[`BIT_LOCK_CH2];
	assign pwm1  = (ch1_mode_q[`MODE_HI:`MODE_LO] == `MODE_PWM1);
	assign pwm2  = (ch2_mode_q[`MODE_HI:`MODE_LO] == `MODE_PWM1);

	// count enables: only the rising-edge code counts on internal ticks
	// limitation: the falling and both-edge codes stop the counter, since the
	// internal tick has no second edge to offer
	logic step1, step2;
	assign step1 = run1 && (ch1_ctrl_q[`EDGE_HI:`EDGE_LO] == `EDGE_RISING)
		&& pick_tick(ch1_ctrl_q, tick1, tick4, tick16, tick64);
	assign step2 = run2 && (ch2_ctrl_q[`EDGE_HI:`EDGE_LO] == `EDGE_RISING)
		&& pick_tick(ch2_ctrl_q, tick1, tick4, tick16, tick64);

	// compare matches are qualified by the tick so each lasts one cycle
	// at /4, without the tick a match would stand for all four clocks of one count
	// and the toggle code would flip the pin four times
	logic m1a, m1b, m2a, m2b;
	assign m1a = step1 && (ch1_count_q == ch1_duty_q);
	assign m1b = step1 && (ch1_count_q == ch1_period_q);
	assign m2a = step2 && (ch2_count_q == ch2_duty_q);
	assign m2b = step2 && (ch2_count_q == ch2_period_q);

	// own clear per channel from its clear-source field
	function automatic logic own_clear(input reg8_t ctrl, input logic ma, input logic mb);
		case (ctrl[`CLR_SRC_HI:`CLR_SRC_LO])
			`CLR_ON_A: own_clear = ma;
			`CLR_ON_B: own_clear = mb;
			default:   own_clear = 1'b0;
		endcase
	endfunction

	logic clr1_own, clr2_own, clr1, clr2, both_locked;
	logic follow1, follow2;
	// sharing needs both lock bits; a single locked channel has no partner to follow
	assign both_locked = lock1 && lock2;
	assign clr1_own = own_clear(ch1_ctrl_q, m1a, m1b);
	assign clr2_own = own_clear(ch2_ctrl_q, m2a, m2b);
	// a channel follows its partner only when its own clear source asks for it
	assign follow1 = both_locked && (ch1_ctrl_q[`CLR_SRC_HI:`CLR_SRC_LO] == `CLR_ON_SYNC);
	assign follow2 = both_locked && (ch2_ctrl_q[`CLR_SRC_HI:`CLR_SRC_LO] == `CLR_ON_SYNC);
	// partner clear: a following channel also clears on its partner's own clear event; both
	// counters drop to zero on the same edge, so the two pins keep their phase
	assign clr1 = clr1_own || (follow1 && clr2_own);
	assign clr2 = clr2_own || (follow2 && clr1_own);

	// counter writes preset the partner too when both are locked
	// the partner takes the same data word, so both start from one value
	logic preset1, preset2;
	assign preset1 = wr_c1cnt || (both_locked && wr_c2cnt);
	assign preset2 = wr_c2cnt || (both_locked && wr_c1cnt);

	// start register: a cleared run bit stops the counter's ticks; a preset or a partner clear can still move it
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			start_q <= `RST_CTRL8;
		else if (wr_start)
			start_q <= wdata_in[7:0];
	end

	// sync register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			sync_q <= `RST_CTRL8;
		else if (wr_sync)
			sync_q <= wdata_in[7:0];
	end

	// channel 1 configuration registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ch1_ctrl_q <= `RST_CTRL8;
			ch1_mode_q <= `RST_CTRL8;
			ch1_io_q   <= `RST_CTRL8;
		end else begin
			if (wr_c1ctrl)
				ch1_ctrl_q <= wdata_in[7:0];
			if (wr_c1mode)
				ch1_mode_q <= wdata_in[7:0];
			if (wr_c1io)
				ch1_io_q <= wdata_in[7:0];
		end
	end

	// channel 2 configuration; its mode byte rides in the upper half of the control word
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ch2_ctrl_q <= `RST_CTRL8;
			ch2_mode_q <= `RST_CTRL8;
			ch2_io_q   <= `RST_CTRL8;
		end else begin
			if (wr_c2ctrl) begin
				ch2_ctrl_q <= wdata_in[7:0];
				ch2_mode_q <= wdata_in[15:8];
			end
			if (wr_c2io)
				ch2_io_q <= wdata_in[7:0];
		end
	end

	// channel 1 compares, whole-word writes only; all ones puts the match on the last count before the counter wraps
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ch1_duty_q   <= `RST_COMPARE;
			ch1_period_q <= `RST_COMPARE;
		end else begin
			if (wr_c1duty)
				ch1_duty_q <= wdata_in;
			if (wr_c1per)
				ch1_period_q <= wdata_in;
		end
	end

	// channel 2 compares
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ch2_duty_q   <= `RST_COMPARE;
			ch2_period_q <= `RST_COMPARE;
		end else begin
			if (wr_c2duty)
				ch2_duty_q <= wdata_in;
			if (wr_c2per)
				ch2_period_q <= wdata_in;
		end
	end

	// counter 1: preset beats clear beats count; a stopped counter holds unless preset or cleared with its partner
	// a preset that lands on the period value is not a match until the next
	// tick, so software may load the counter anywhere inside the cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			ch1_count_q <= `RST_COUNT;
		else if (preset1)
			ch1_count_q <= wdata_in;
		else if (clr1)
			ch1_count_q <= `RST_COUNT;
		else if (step1)
			ch1_count_q <= ch1_count_q + 16'h0001;
	end

	// counter 2: same priorities; when locked it also takes the word written
	// to counter 1
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			ch2_count_q <= `RST_COUNT;
		else if (preset2)
			ch2_count_q <= wdata_in;
		else if (clr2)
			ch2_count_q <= `RST_COUNT;
		else if (step2)
			ch2_count_q <= ch2_count_q + 16'h0001;
	end

	// read data stands one cycle after the strobe; unmapped reads give zero
	// the bus is driven to zero between answers so a master that samples late
	// sees an obvious blank rather than a stale register value
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_out <= '0;
		end else if (read_in) begin
			case (addr_in)
				`ADDR_START_CTRL: rdata_out <= {8'h00, start_q};
				`ADDR_SYNC_SEL:   rdata_out <= {8'h00, sync_q};
				`ADDR_CH1_CTRL:   rdata_out <= {8'h00, ch1_ctrl_q};
				`ADDR_CH1_MODE:   rdata_out <= {8'h00, ch1_mode_q};
				`ADDR_CH1_IO:     rdata_out <= {8'h00, ch1_io_q};
				`ADDR_CH1_COUNT:  rdata_out <= ch1_count_q;
				`ADDR_CH1_DUTY:   rdata_out <= ch1_duty_q;
				`ADDR_CH1_PERIOD: rdata_out <= ch1_period_q;
				`ADDR_CH2_CTRL:   rdata_out <= {ch2_mode_q, ch2_ctrl_q};
				`ADDR_CH2_IO:     rdata_out <= {8'h00, ch2_io_q};
				`ADDR_CH2_COUNT:  rdata_out <= ch2_count_q;
				`ADDR_CH2_DUTY:   rdata_out <= ch2_duty_q;
				`ADDR_CH2_PERIOD: rdata_out <= ch2_period_q;
				default:          rdata_out <= '0;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end

	// pin logic; io writes reload the initial levels
	// the initial level is taken from bit 2 of each io field, the matched level
	// from its low two bits, so one field sets both start and match behaviour
	compare_pin u_pin_a1 (
		.clk_in         (clk_in),
		.reset_in       (reset_in),
		.pwm_mode_in    (pwm1),
		.io_a_in        (ch1_io_q[`IOA_HI:`IOA_LO]),
		.io_b_in        (ch1_io_q[`IOB_HI:`IOB_LO]),
		.use_a_field_in (1'b1),
		.cfg_write_in   (wr_c1io),
		.match_a_in     (m1a),
		.match_b_in     (m1b),
		.pin_out        (ch1_pwm_pin_out)
	);

	// b pin only follows its own field, and never acts in pwm mode
	compare_pin u_pin_b1 (
		.clk_in         (clk_in),
		.reset_in       (reset_in),
		.pwm_mode_in    (1'b0),
		.io_a_in        (ch1_io_q[`IOA_HI:`IOA_LO]),
		.io_b_in        (ch1_io_q[`IOB_HI:`IOB_LO]),
		.use_a_field_in (1'b0),
		.cfg_write_in   (wr_c1io),
		.match_a_in     (1'b0),
		.match_b_in     (m1b && !pwm1),
		.pin_out        (ch1_aux_compare_pin_out)
	);

	compare_pin u_pin_a2 (
		.clk_in         (clk_in),
		.reset_in       (reset_in),
		.pwm_mode_in    (pwm2),
		.io_a_in        (ch2_io_q[`IOA_HI:`IOA_LO]),
		.io_b_in        (ch2_io_q[`IOB_HI:`IOB_LO]),
		.use_a_field_in (1'b1),
		.cfg_write_in   (wr_c2io),
		.match_a_in     (m2a),
		.match_b_in     (m2b),
		.pin_out        (ch2_pwm_pin_out)
	);
endmodule

// file: synced_two_channel_pwm_timer_chk.sv
`timescale 1ns/1ps
module pwm_timer_chk (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        reset_in,
	// register port
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic        write_in,
	input wire logic        read_in,
	input wire logic [15:0] rdata_out,
	// compare pins
	input wire logic        ch1_pwm_pin_out,
	input wire logic        ch1_aux_compare_pin_out,
	input wire logic        ch2_pwm_pin_out
);
	logic [7:0] start_q;
	logic [7:0] sync_q;
	logic       per_wr_q;
	logic       io_wr_q;
	logic       rd_cnt1;
	logic       mapped;
	logic       byte_reg;
	assign rd_cnt1 = read_in && addr_in == 16'hf046;
	assign mapped = addr_in inside {16'hf030, 16'hf031, 16'hf040, 16'hf041, 16'hf042,
		16'hf046, 16'hf048, 16'hf04a, 16'hf050, 16'hf052, 16'hf056, 16'hf058, 16'hf05a};
	assign byte_reg = addr_in inside {16'hf030, 16'hf031, 16'hf040, 16'hf041, 16'hf042,
		16'hf052};
	// shadows of software writes, so checks know run, lock and first-write state
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			start_q <= 8'h00;
			sync_q <= 8'h00;
			per_wr_q <= 1'b0;
			io_wr_q <= 1'b0;
		end else if (write_in) begin
			if (addr_in == 16'hf030) start_q <= wdata_in[7:0];
			if (addr_in == 16'hf031) sync_q <= wdata_in[7:0];
			if (addr_in == 16'hf04a) per_wr_q <= 1'b1;
			if (addr_in inside {16'hf042, 16'hf052}) io_wr_q <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_idle_read_zero: assert property (!$past(read_in) |-> rdata_out == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_unmapped_read_zero: assert property (read_in && !mapped |=> rdata_out == 16'h0000)
		else $error("unmapped read gave data");
	a_byte_upper_zero: assert property (read_in && byte_reg |=> rdata_out[15:8] == 8'h00)
		else $error("upper byte of an 8-bit register not zero");
	a_start_bits_readback: assert property (
		write_in && addr_in == 16'hf030 ##1 read_in && addr_in == 16'hf030
		|=> rdata_out[2:1] == $past(wdata_in[2:1], 2))
		else $error("start bits read back wrong");
	a_period_reset_ones: assert property (
		read_in && addr_in == 16'hf04a && !per_wr_q |=> rdata_out == 16'hffff)
		else $error("period compare not all ones before first write");
	a_stopped_count_hold: assert property (
		rd_cnt1 && !start_q[1] ##1 rd_cnt1 |=> rdata_out == $past(rdata_out))
		else $error("stopped counter 1 moved");
	a_sync_preset_both: assert property (
		write_in && addr_in == 16'hf046 && sync_q[2:1] == 2'h3 && start_q[2:1] == 2'h0
		##1 read_in && addr_in == 16'hf056 |=> rdata_out == $past(wdata_in, 2))
		else $error("counter 2 not preset with counter 1");
	a_pins_idle_low: assert property (
		!io_wr_q |-> !ch1_pwm_pin_out && !ch1_aux_compare_pin_out && !ch2_pwm_pin_out)
		else $error("pin moved before any io setup");
	c_back_reads: cover property (rd_cnt1 ##1 rd_cnt1);
	c_sync_write: cover property (write_in && addr_in == 16'hf046 && sync_q[2:1] == 2'h3);
	c_pwm_rise: cover property ($rose(ch1_pwm_pin_out));
	c_pwm2_fall: cover property ($fell(ch2_pwm_pin_out));
endmodule

bind synced_two_channel_pwm_timer pwm_timer_chk chk_u (
	.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
	.ch1_pwm_pin_out(ch1_pwm_pin_out), .ch1_aux_compare_pin_out(ch1_aux_compare_pin_out),
	.ch2_pwm_pin_out(ch2_pwm_pin_out));

// file: synced_two_channel_pwm_timer_tb.sv
`timescale 1ns/1ps
module synced_two_channel_pwm_timer_tb;
	import pwm_timer_pkg::*;
	logic        clk_in;
	logic        reset_in;
	logic [15:0] addr_in;
	logic [15:0] wdata_in;
	logic        write_in;
	logic        read_in;
	logic [15:0] rdata_out;
	logic        pin1;
	logic        pin_aux;
	logic        pin2;
	int          bad_count;
	int          checks;
	int          cycles;
	logic [15:0] d;
	logic [15:0] h1;
	logic [15:0] h2;
	logic [15:0] ha;
	logic [15:0] ta [5] = '{16'hf040, 16'hf041, 16'hf042, 16'hf031, 16'hf030};
	logic [15:0] tv [5] = '{16'hff41, 16'hff02, 16'hff12, 16'hff06, 16'hff00};
	synced_two_channel_pwm_timer dut_u (
		.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
		.ch1_pwm_pin_out(pin1), .ch1_aux_compare_pin_out(pin_aux), .ch2_pwm_pin_out(pin2));
	// 40 MHz system clock
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// tasks start just after an edge so strobes may run back to back
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		addr_in <= a;
		wdata_in <= v;
		write_in <= 1'b1;
		@(posedge clk_in);
		write_in <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		addr_in <= a;
		read_in <= 1'b1;
		@(posedge clk_in);
		read_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_rng(input string n, input logic [15:0] lo, input logic [15:0] hi,
		input logic [15:0] g);
		checks++;
		if ($isunknown(g) || g < lo || g > hi) begin
			bad_count++;
			$display("unexpected %s expected %h..%h seen %h", n, lo, hi, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		reset_in = 1'b1;
		addr_in = 16'h0000;
		wdata_in = 16'h0000;
		write_in = 1'b0;
		read_in = 1'b0;
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		// reset values and the unmapped hole
		rd(16'hf046, d);
		chk("count1 reset", 16'h0000, d);
		rd(16'hf04a, d);
		chk("period1 reset", 16'hffff, d);
		rd(16'hf048, d);
		chk("duty1 reset", 16'hffff, d);
		wr(16'hf0ee, 16'h5a5a);
		rd(16'hf0ee, d);
		chk("unmapped", 16'h0000, d);
		$display("test reset done");
		// 8-bit registers hold the low byte only; write then read back to back
		for (int i = 0; i < 5; i++) begin
			wr(ta[i], tv[i]);
			rd(ta[i], d);
			chk("byte reg", {8'h00, tv[i][7:0]}, d);
		end
		$display("test config done");
		// locked preset while stopped, then both counters hold
		wr(16'hf046, 16'h1234);
		rd(16'hf056, d);
		chk("count2 preset", 16'h1234, d);
		repeat (20) @(posedge clk_in);
		rd(16'hf046, d);
		chk("count1 held", 16'h1234, d);
		rd(16'hf046, d);
		chk("count1 held again", 16'h1234, d);
		rd(16'hf056, d);
		chk("count2 held", 16'h1234, d);
		$display("test stop done");
		// unlocked: ch1 counts at clock over four, ch2 stays put
		wr(16'hf031, 16'h0000);
		wr(16'hf04a, 16'hffff);
		wr(16'hf056, 16'h0100);
		wr(16'hf046, 16'h0000);
		wr(16'hf030, 16'h0002);
		repeat (40) @(posedge clk_in);
		wr(16'hf030, 16'h0000);
		rd(16'hf046, d);
		chk_rng("count1 rate", 16'h0009, 16'h000b, d);
		rd(16'hf056, d);
		chk("count2 unlocked", 16'h0100, d);
		$display("test rate done");
		// locked pwm: period 7 shared, duty 3 on ch1, 5..6 window on ch2
		wr(16'hf031, 16'h0006);
		wr(16'hf04a, 16'h0007);
		wr(16'hf048, 16'h0003);
		wr(16'hf050, 16'h0261);
		wr(16'hf052, 16'h0012);
		rd(16'hf052, d);
		chk("ch2 io", 16'h0012, d);
		wr(16'hf058, 16'h0005);
		wr(16'hf05a, 16'h0006);
		wr(16'hf046, 16'h0000);
		wr(16'hf030, 16'h0006);
		repeat (40) @(posedge clk_in);
		h1 = 16'h0000;
		h2 = 16'h0000;
		ha = 16'h0000;
		// two whole periods of 32 cycles, so the phase does not matter
		repeat (64) begin
			@(posedge clk_in);
			#1;
			h1 = h1 + {15'h0000, pin1};
			h2 = h2 + {15'h0000, pin2};
			ha = ha + {15'h0000, pin_aux};
		end
		chk("pwm1 high", 16'h0020, h1);
		chk("pwm2 high", 16'h0008, h2);
		chk("aux pin", 16'h0000, ha);
		rd(16'hf046, d);
		chk_rng("count1 bound", 16'h0000, 16'h0007, d);
		rd(16'hf056, d);
		chk_rng("count2 bound", 16'h0000, 16'h0007, d);
		$display("test pwm done");
		tally_and_finish();
	end
endmodule
